// ---- core/uss_cfg.svh ----
// Register map, field positions and reset values of the serial shift unit
`ifndef USS_CFG_SVH
`define USS_CFG_SVH

// Register byte offsets on the APB bus
`define USS_OFS_DATA 8'h00
`define USS_OFS_STATUS 8'h04
`define USS_OFS_CONTROL 8'h08
`define USS_OFS_PORT 8'h0C

// Status register fields
`define USS_ST_START 7
`define USS_ST_OVF 6
`define USS_ST_STOP 5
`define USS_ST_COLL 4
`define USS_ST_CNT_HI 3
`define USS_ST_CNT_LO 0

// Control register fields
`define USS_CTL_SIE 7
`define USS_CTL_OIE 6
`define USS_CTL_WM_HI 5
`define USS_CTL_WM_LO 4
`define USS_CTL_CS_HI 3
`define USS_CTL_CS_LO 2
`define USS_CTL_CLK 1
`define USS_CTL_TC 0
`define USS_CTL_RD_MASK 8'hFC

// Port and direction register fields
`define USS_PORT_DO 0
`define USS_PORT_SDA 1
`define USS_PORT_SCL 2
`define USS_DDR_DO 4
`define USS_DDR_SDA 5
`define USS_DDR_SCL 6

// Counter and reset constants
`define USS_CNT_MAX 4'hF
`define USS_CNT_ONE 4'h1
`define USS_RST_BYTE 8'h00
`define USS_RST_CNT 4'h0
`define USS_RD_PAD 24'h000000

`endif

// ---- core/uss_pkg.sv ----
// Types shared by the serial shift unit
package uss_pkg;

    // Wire mode field, in encoding order
    typedef enum logic [1:0] {
        USS_WM_OFF,
        USS_WM_THREE,
        USS_WM_TWO,
        USS_WM_TWO_HOLD
    } uss_wire_mode_type;

    // Clock source field, in encoding order
    typedef enum logic [1:0] {
        USS_CS_SOFT,
        USS_CS_TIMER,
        USS_CS_EXT_RISE,
        USS_CS_EXT_FALL
    } uss_clk_src_type;

endpackage

// ---- core/uss_sync.sv ----
// Two-stage synchroniser for pin inputs of the serial shift unit
`timescale 1ns/100ps

module uss_sync
#(
    parameter int WIDTH = 2
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    ////////////////////////////////////////////////////////////////////////
    // One pair of flops per bit; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            logic meta_reg; // First stage, may go metastable
            logic stable_reg; // Second stage, safe to use

            // Chain of two flops clocked by the system clock
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= d[i];
                    stable_reg <= meta_reg;
                end
            end

            assign q[i] = stable_reg;
        end
    endgenerate

endmodule

// ---- core/uss_top.sv ----
// Serial shift unit: shift register, 4-bit counter, status, control, pins
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "uss_cfg.svh"

// How it works
// - Data register is the live shifter
// - Write in shift cycle wins, no shift
// - Shift left, clocked by selected source
// - Pins feed shifter and counter when off
// - Data pin driven from bit 7 latch
// - Latch open first half when external
// - Start flag: start condition or counter tick
// - Start flag interrupts, write-one clears, releases
// - Start interrupt wakes from every sleep
// - Overflow flag on 15 to 0 wrap
// - Overflow interrupt wakes from idle only
// - Stop flag in two-wire, no interrupt
// - Collision when bit 7 differs from pin
// - Counter value readable and writable in status
// - Counter ticks on selected clock source
// - Enables gate pending flags immediately
// - Wire mode changes outputs and start flag source
// - Mode off: outputs, hold, detector disabled
// - Three-wire: data output overrides port bit
// - Two-wire: open drain, start hold, no SDA/SCL pull-ups
// - Hold mode also holds clock after overflow
// - Clock source field selects edge or strobe
// - Toggle strobe inverts clock port, reads zero
module uss_top
    import uss_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SERIAL_IN_PIN,
    input wire logic SERIAL_CLOCK_PIN,
    input wire logic TIMER0_MATCH,
    input wire logic GLOBAL_IRQ_EN,
    input wire logic SLEEP_DEEP,
    output logic DATA_OUT_O,
    output logic DATA_OUT_OE,
    output logic DATA_OUT_PULLUP,
    output logic SDA_O,
    output logic SDA_OE,
    output logic SDA_PULLUP,
    output logic SCL_O,
    output logic SCL_OE,
    output logic SCL_PULLUP,
    output logic START_IRQ,
    output logic OVERFLOW_IRQ,
    output logic WAKE_REQ
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [1:0] pin_sync; // Synchronised data and clock pins
    logic din_s; // Data pin level after synchroniser
    logic sclk_s; // Clock pin level after synchroniser
    logic din_prev_reg; // Data pin one cycle back
    logic sclk_prev_reg; // Clock pin one cycle back
    logic [7:0] data_reg; // Live shift register
    logic [7:0] data_next;
    logic [3:0] cnt_reg; // 4-bit counter
    logic [3:0] cnt_next;
    logic start_flag_reg; // Start condition flag
    logic start_flag_next;
    logic ovf_flag_reg; // Counter overflow flag
    logic ovf_flag_next;
    logic stop_flag_reg; // Stop condition flag
    logic stop_flag_next;
    logic start_hold_reg; // Clock held low after a start
    logic start_hold_next;
    logic [7:0] ctrl_reg; // Control; bit 1 keeps the strobe select
    logic [7:0] ctrl_next;
    logic [7:0] port_reg; // Port values and directions of the three pins
    logic [7:0] port_next;
    logic latch_reg; // Output latch behind bit 7
    logic latch_next;
    logic [31:0] prdata_reg; // Read data, captured in the setup phase
    logic [31:0] prdata_next;

    ////////////////////////////////////////////////////////////////////////
    // Assertion defaults: one clock domain, synchronous reset
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; both pins are sampled in every wire mode
    uss_sync #(.WIDTH(2)) u_sync
    (
        .clk(CLK_SYS),
        .rst(RST),
        .d({SERIAL_CLOCK_PIN, SERIAL_IN_PIN}),
        .q(pin_sync)
    );

    assign din_s = pin_sync[0];
    assign sclk_s = pin_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // APB decode; the slave never inserts wait states
    wire access_phase = PSEL & PENABLE;
    wire setup_phase = PSEL & ~PENABLE;
    wire hit_data = (PADDR == `USS_OFS_DATA);
    wire hit_status = (PADDR == `USS_OFS_STATUS);
    wire hit_control = (PADDR == `USS_OFS_CONTROL);
    wire hit_port = (PADDR == `USS_OFS_PORT);
    wire hit_any = hit_data | hit_status | hit_control | hit_port;
    wire wr_en = access_phase & PWRITE;
    wire wr_data = wr_en & hit_data;
    wire wr_status = wr_en & hit_status;
    wire wr_ctrl = wr_en & hit_control;
    wire wr_port = wr_en & hit_port;

    assign PREADY = 1'b1;
    // Unmapped addresses complete with an error and read as zero
    assign PSLVERR = access_phase & ~hit_any;
    assign PRDATA = prdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Field views of control and port registers
    wire uss_wire_mode_type wire_mode =
        uss_wire_mode_type'(ctrl_reg[`USS_CTL_WM_HI:`USS_CTL_WM_LO]);
    wire uss_clk_src_type clk_src = uss_clk_src_type'(ctrl_reg[`USS_CTL_CS_HI:`USS_CTL_CS_LO]);
    wire two_wire = ctrl_reg[`USS_CTL_WM_HI];
    wire ext_clk = ctrl_reg[`USS_CTL_CS_HI];
    wire clk_sel = ctrl_reg[`USS_CTL_CLK];
    wire port_do = port_reg[`USS_PORT_DO];
    wire port_sda = port_reg[`USS_PORT_SDA];
    wire port_scl = port_reg[`USS_PORT_SCL];
    wire ddr_do = port_reg[`USS_DDR_DO];
    wire ddr_sda = port_reg[`USS_DDR_SDA];
    wire ddr_scl = port_reg[`USS_DDR_SCL];

    ////////////////////////////////////////////////////////////////////////
    // Edge and bus condition detection on synchronised pins
    wire scl_rise = sclk_s & ~sclk_prev_reg;
    wire scl_fall = ~sclk_s & sclk_prev_reg;
    // SDA edges while SCL stays high; the pins take equal delay, so their order is kept
    wire start_det = din_prev_reg & ~din_s & sclk_s & sclk_prev_reg;
    wire stop_det = ~din_prev_reg & din_s & sclk_s & sclk_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Clock strobes; decoded from the control value being written, the timer tick from the stored source
    wire wr_cs_soft = (PWDATA[`USS_CTL_CS_HI:`USS_CTL_CS_LO] == USS_CS_SOFT);
    wire soft_strobe = wr_ctrl & PWDATA[`USS_CTL_CLK] & wr_cs_soft;
    wire tc_strobe = wr_ctrl & PWDATA[`USS_CTL_TC];
    wire tc_count = tc_strobe & PWDATA[`USS_CTL_CLK] & PWDATA[`USS_CTL_CS_HI];
    wire timer_tick = (clk_src == USS_CS_TIMER) & TIMER0_MATCH;

    // Shift clock follows the selected edge even when the counter uses the toggle
    wire shift_tick = soft_strobe | timer_tick
        | ((clk_src == USS_CS_EXT_RISE) & scl_rise)
        | ((clk_src == USS_CS_EXT_FALL) & scl_fall);

    // With an external source the counter sees both pin edges unless the toggle strobe is selected
    wire count_tick = soft_strobe | timer_tick | tc_count
        | (ext_clk & ~clk_sel & (scl_rise | scl_fall));

    wire wrap = count_tick & (cnt_reg == `USS_CNT_MAX);

    ////////////////////////////////////////////////////////////////////////
    // Shift register; a bus write beats a shift in the same cycle
    always_comb
    begin
        if (wr_data)
            data_next = PWDATA[7:0];
        else if (shift_tick)
            data_next = {data_reg[6:0], din_s};
        else
            data_next = data_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter: direct write has priority over a tick
    always_comb
    begin
        if (wr_status)
            cnt_next = PWDATA[`USS_ST_CNT_HI:`USS_ST_CNT_LO];
        else if (count_tick)
            cnt_next = cnt_reg + `USS_CNT_ONE;
        else
            cnt_next = cnt_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: set wins over a write-one clear in the same cycle
    wire clr_start = wr_status & PWDATA[`USS_ST_START];
    wire clr_ovf = wr_status & PWDATA[`USS_ST_OVF];
    wire clr_stop = wr_status & PWDATA[`USS_ST_STOP];
    // The detector is off outside two-wire mode; counter ticks set it there
    wire start_set = two_wire ? start_det : count_tick;
    wire stop_set = two_wire & stop_det;
    // Hold follows the mode being written, so leaving two-wire drops it at once
    wire two_wire_next = ctrl_next[`USS_CTL_WM_HI];

    always_comb
    begin
        start_flag_next = start_set | (start_flag_reg & ~clr_start);
        ovf_flag_next = wrap | (ovf_flag_reg & ~clr_ovf);
        stop_flag_next = stop_set | (stop_flag_reg & ~clr_stop);
        // Hold begins at the first SCL fall after a start, ends with the flag
        start_hold_next = two_wire_next & start_flag_next
            & (start_hold_reg | scl_fall);
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and port registers; the toggle strobe bit 0 is never stored as set
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl)
            ctrl_next = {PWDATA[7:1], 1'b0};
        port_next = port_reg;
        if (wr_port)
            port_next = PWDATA[7:0];
        else if (tc_strobe)
            port_next[`USS_PORT_SCL] = ~port_scl;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output latch: open in the first half of an external clock cycle
    // Open while the pin sits at the level opposite the sampling edge
    wire latch_open = ~ext_clk | (sclk_s == ctrl_reg[`USS_CTL_CS_LO]);
    wire data_bit = latch_open ? data_reg[7] : latch_reg;

    assign latch_next = data_bit;

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; a read sees the live shifter, no buffer copy
    wire [7:0] status_view = {start_flag_reg, ovf_flag_reg, stop_flag_reg,
        data_reg[7] ^ din_s, cnt_reg};
    wire [7:0] rd_byte = hit_data ? data_reg
        : hit_status ? status_view
        : hit_control ? (ctrl_reg & `USS_CTL_RD_MASK)
        : hit_port ? port_reg
        : `USS_RST_BYTE;

    assign prdata_next = setup_phase ? {`USS_RD_PAD, rd_byte} : prdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // State flops
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            data_reg <= `USS_RST_BYTE;
            cnt_reg <= `USS_RST_CNT;
            ctrl_reg <= `USS_RST_BYTE;
            port_reg <= `USS_RST_BYTE;
            {start_flag_reg, ovf_flag_reg, stop_flag_reg} <= 3'h0;
            {start_hold_reg, latch_reg} <= 2'h0;
            {din_prev_reg, sclk_prev_reg} <= 2'h0;
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            data_reg <= data_next;
            cnt_reg <= cnt_next;
            ctrl_reg <= ctrl_next;
            port_reg <= port_next;
            {start_flag_reg, ovf_flag_reg, stop_flag_reg} <=
                {start_flag_next, ovf_flag_next, stop_flag_next};
            {start_hold_reg, latch_reg} <= {start_hold_next, latch_next};
            {din_prev_reg, sclk_prev_reg} <= {din_s, sclk_s};
            prdata_reg <= prdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers; only the output side depends on the wire mode
    wire three_wire = (wire_mode == USS_WM_THREE);
    wire ovf_hold = (wire_mode == USS_WM_TWO_HOLD) & ovf_flag_reg;
    // Open-drain pulls low on a zero from the shifter or the port bit
    wire sda_low = ~data_bit | ~port_sda;
    wire scl_low = ~port_scl | start_hold_reg | ovf_hold;

    // Data output pin overrides the port bit only in three-wire mode
    assign DATA_OUT_O = three_wire ? data_bit : port_do;
    assign DATA_OUT_OE = ddr_do;
    assign DATA_OUT_PULLUP = ~ddr_do & port_do;
    // Off and three-wire leave the data and clock pins as plain port pins
    assign SDA_O = two_wire ? 1'b0 : port_sda;
    assign SDA_OE = ddr_sda & (~two_wire | sda_low);
    assign SDA_PULLUP = ~two_wire & ~ddr_sda & port_sda;
    assign SCL_O = two_wire ? 1'b0 : port_scl;
    assign SCL_OE = ddr_scl & (~two_wire | scl_low);
    assign SCL_PULLUP = ~two_wire & ~ddr_scl & port_scl;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt requests; a pending flag fires as soon as enables allow
    assign START_IRQ = start_flag_reg & ctrl_reg[`USS_CTL_SIE] & GLOBAL_IRQ_EN;
    assign OVERFLOW_IRQ = ovf_flag_reg & ctrl_reg[`USS_CTL_OIE] & GLOBAL_IRQ_EN;
    // Start detection is sampled here, so deep sleep needs this clock running
    assign WAKE_REQ = START_IRQ | (OVERFLOW_IRQ & ~SLEEP_DEEP);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_write_beats_shift: assert property (
        wr_data |=> data_reg == $past(PWDATA[7:0]))
        else $error("data write lost or shifted");

    chk_shift_left_in: assert property (
        shift_tick && !wr_data |=> data_reg == {$past(data_reg[6:0]), $past(din_s)})
        else $error("shift register did not shift left");

    chk_count_wrap: assert property (
        wrap && !wr_status |=> cnt_reg == `USS_RST_CNT && ovf_flag_reg)
        else $error("counter wrap did not set overflow");

    chk_start_on_tick: assert property (
        count_tick && !two_wire |=> start_flag_reg)
        else $error("counter tick did not set start flag");

    chk_flag_sticky: assert property (
        start_flag_reg && !(wr_status && PWDATA[`USS_ST_START]) |=> start_flag_reg)
        else $error("start flag dropped without a clear");

    chk_overflow_hold: assert property (
        wire_mode == USS_WM_TWO_HOLD && ovf_flag_reg && ddr_scl |-> SCL_OE && !SCL_O)
        else $error("clock not held low after overflow");

    chk_mode_off_port: assert property (
        wire_mode == USS_WM_OFF |-> SDA_O == port_sda && !start_hold_reg)
        else $error("outputs active with wire mode off");

    chk_toggle_clock: assert property (
        tc_strobe |=> port_scl == !$past(port_scl))
        else $error("toggle strobe did not invert clock port");

    chk_strobe_read: assert property (
        setup_phase && hit_control |=> PRDATA[1:0] == 2'h0)
        else $error("strobe bits read as one");

    chk_deep_wake: assert property (
        SLEEP_DEEP && !START_IRQ |-> !WAKE_REQ)
        else $error("overflow woke from deep sleep");

    chk_write_count: assert property (
        wr_status |=> cnt_reg == $past(PWDATA[`USS_ST_CNT_HI:`USS_ST_CNT_LO]))
        else $error("counter write not taken");

    cov_byte_done: cover property (wrap && ext_clk);
    cov_start_seen: cover property (two_wire && start_det ##[1:50] start_hold_reg);
    cov_soft_shift: cover property (soft_strobe ##1 soft_strobe);

endmodule

// ---- sim/uss_peer.sv ----
// Serial peer model: bus master on the three-wire or two-wire link
`timescale 1ns/100ps

module uss_peer
#(
    parameter int HALF_NS = 100
)
(
    input wire logic data_from_dut,
    output logic sda_rel,
    output logic scl_rel
);
    ////////////////////////////////////////////////////////////////////////
    // Lines released (1) at rest; the wire pull-up then reads high,
    // so the last driven bit never lingers between frames
    initial
    begin
        sda_rel = 1'h1;
        scl_rel = 1'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One byte MSB first; data set as clock falls, the peer samples on rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            scl_rel = 1'h0;
            sda_rel = tx[i];
            #(HALF_NS);
            scl_rel = 1'h1;
            rx[i] = data_from_dut;
            #(HALF_NS);
        end
        sda_rel = 1'h1;
        #(HALF_NS);
    endtask

    // Data falls while clock high, then clock pulled low and released
    task automatic start_cond();
        sda_rel = 1'h0;
        #(HALF_NS);
        scl_rel = 1'h0;
        #(HALF_NS);
        scl_rel = 1'h1;
        #(HALF_NS);
    endtask

    // Data rises while clock high; clock stands still afterwards
    task automatic stop_cond();
        scl_rel = 1'h0;
        #(HALF_NS);
        sda_rel = 1'h0;
        #(HALF_NS);
        scl_rel = 1'h1;
        #(HALF_NS);
        sda_rel = 1'h1;
        #(HALF_NS);
    endtask
endmodule

// ---- sim/uss_top_tb.sv ----
// Self-checking bench for the serial shift unit
`timescale 1ns/100ps
`include "uss_cfg.svh"

module uss_top_tb;
    logic CLK_SYS = 1'h0;
    logic RST = 1'h1;
    logic PSEL = 1'h0;
    logic PENABLE = 1'h0;
    logic PWRITE = 1'h0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h00000000;
    logic TIMER0_MATCH = 1'h0;
    logic GLOBAL_IRQ_EN = 1'h0;
    logic SLEEP_DEEP = 1'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, DATA_OUT_O, DATA_OUT_OE, DATA_OUT_PULLUP;
    logic SDA_O, SDA_OE, SDA_PULLUP, SCL_O, SCL_OE, SCL_PULLUP;
    logic START_IRQ, OVERFLOW_IRQ, WAKE_REQ;
    logic sda_rel, scl_rel;
    logic tmr_on_wr = 1'h0; // Timer pulse lands on the write edge
    int n_mismatch = 0;
    int cmp_count = 0;
    // Wire level: pulled up, low if any party pulls it low
    wire SERIAL_IN_PIN = sda_rel & (SDA_OE ? SDA_O : 1'h1);
    wire SERIAL_CLOCK_PIN = scl_rel & (SCL_OE ? SCL_O : 1'h1);

    always #12.5 CLK_SYS = ~CLK_SYS;

    uss_top i_uss_top (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SERIAL_IN_PIN(SERIAL_IN_PIN), .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN),
        .TIMER0_MATCH(TIMER0_MATCH), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .SLEEP_DEEP(SLEEP_DEEP),
        .DATA_OUT_O(DATA_OUT_O), .DATA_OUT_OE(DATA_OUT_OE), .DATA_OUT_PULLUP(DATA_OUT_PULLUP),
        .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SDA_PULLUP(SDA_PULLUP), .SCL_O(SCL_O),
        .SCL_OE(SCL_OE), .SCL_PULLUP(SCL_PULLUP), .START_IRQ(START_IRQ),
        .OVERFLOW_IRQ(OVERFLOW_IRQ), .WAKE_REQ(WAKE_REQ));

    uss_peer i_uss_peer (.data_from_dut(DATA_OUT_O), .sda_rel(sda_rel), .scl_rel(scl_rel));

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Let the edge's register updates land before pins are sampled
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask

    // One APB transfer; wait for pready is bounded, overrun ends the run
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wdat,
                       output logic [7:0] rdat, output logic err);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        PSEL <= 1'h1;
        PWRITE <= wr;
        PADDR <= addr;
        PWDATA <= {24'h000000, wdat};
        @(posedge CLK_SYS);
        PENABLE <= 1'h1;
        TIMER0_MATCH <= tmr_on_wr;
        do
        begin
            @(posedge CLK_SYS);
            n++;
        end
        while (PREADY !== 1'h1 && n < 16);
        if (PREADY !== 1'h1)
        begin
            n_mismatch++;
            results();
        end
        rdat = PRDATA[7:0];
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        TIMER0_MATCH <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'h1, addr, d, r, e);
    endtask

    // Masked read compare; the mask hides fields the scenario does not fix
    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp,
                          input logic [7:0] mask);
        logic [7:0] r;
        logic e;
        apb(1'h0, addr, 8'h00, r, e);
        cmp(what, exp, r & mask);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] r;
        logic e;
        rd_chk("data", `USS_OFS_DATA, 8'h00, 8'hFF);
        rd_chk("status", `USS_OFS_STATUS, 8'h00, 8'hEF);
        rd_chk("control", `USS_OFS_CONTROL, 8'h00, 8'hFF);
        cmp("oe", 8'h00, {5'h00, DATA_OUT_OE, SDA_OE, SCL_OE});
        apb(1'h0, 8'h10, 8'h00, r, e);
        cmp("unmapped err", 8'h01, {7'h00, e});
        cmp("unmapped data", 8'h00, r);
        $display("test reset done");
    endtask

    // Software strobe in three-wire mode
    task automatic t_soft();
        wr(`USS_OFS_CONTROL, 8'h10);
        wr(`USS_OFS_DATA, 8'hA5);
        tick(1);
        cmp("do after write", 8'h01, {7'h00, DATA_OUT_O});
        wr(`USS_OFS_CONTROL, 8'h12);
        tick(1);
        cmp("do after strobe", 8'h00, {7'h00, DATA_OUT_O});
        rd_chk("data", `USS_OFS_DATA, 8'h4B, 8'hFF);
        rd_chk("status", `USS_OFS_STATUS, 8'h91, 8'hFF);
        rd_chk("control", `USS_OFS_CONTROL, 8'h10, 8'hFF);
        wr(`USS_OFS_CONTROL, 8'h11);
        rd_chk("port toggle", `USS_OFS_PORT, 8'h04, 8'h04);
        $display("test soft strobe done");
    endtask

    // Timer clocking, wrap, interrupts, wake, write beating a shift
    task automatic t_ovf();
        wr(`USS_OFS_STATUS, 8'hCF);
        wr(`USS_OFS_CONTROL, 8'h54);
        @(posedge CLK_SYS);
        GLOBAL_IRQ_EN <= 1'h1;
        TIMER0_MATCH <= 1'h1;
        @(posedge CLK_SYS);
        TIMER0_MATCH <= 1'h0;
        tick(1);
        cmp("ovf irq", 8'h01, {7'h00, OVERFLOW_IRQ});
        cmp("wake idle", 8'h01, {7'h00, WAKE_REQ});
        @(posedge CLK_SYS);
        SLEEP_DEEP <= 1'h1;
        tick(1);
        cmp("wake deep", 8'h00, {7'h00, WAKE_REQ});
        rd_chk("status wrap", `USS_OFS_STATUS, 8'hC0, 8'hEF);
        tmr_on_wr = 1'h1;
        wr(`USS_OFS_DATA, 8'h5A);
        tmr_on_wr = 1'h0;
        rd_chk("data kept", `USS_OFS_DATA, 8'h5A, 8'hFF);
        rd_chk("count", `USS_OFS_STATUS, 8'h01, 8'h0F);
        wr(`USS_OFS_STATUS, 8'h40);
        rd_chk("ovf cleared", `USS_OFS_STATUS, 8'h00, 8'h40);
        cmp("ovf irq off", 8'h00, {7'h00, OVERFLOW_IRQ});
        wr(`USS_OFS_CONTROL, 8'h94);
        tick(1);
        cmp("start irq", 8'h01, {7'h00, START_IRQ});
        cmp("wake start", 8'h01, {7'h00, WAKE_REQ});
        @(posedge CLK_SYS);
        GLOBAL_IRQ_EN <= 1'h0;
        SLEEP_DEEP <= 1'h0;
        tick(1);
        cmp("start irq off", 8'h00, {7'h00, START_IRQ});
        $display("test overflow done");
    endtask

    // External clocking from the peer, rising then falling edge source
    task automatic t_three();
        logic [7:0] rx;
        wr(`USS_OFS_PORT, 8'h10);
        wr(`USS_OFS_CONTROL, 8'h18);
        wr(`USS_OFS_DATA, 8'h3C);
        wr(`USS_OFS_STATUS, 8'hE0);
        tick(1);
        i_uss_peer.xfer(8'hC5, rx);
        cmp("peer rx", 8'h3C, rx);
        cmp("do oe", 8'h01, {7'h00, DATA_OUT_OE});
        rd_chk("data rx", `USS_OFS_DATA, 8'hC5, 8'hFF);
        rd_chk("status", `USS_OFS_STATUS, 8'hC0, 8'hFF);
        wr(`USS_OFS_CONTROL, 8'h0C);
        wr(`USS_OFS_STATUS, 8'hE0);
        tick(1);
        i_uss_peer.xfer(8'h96, rx);
        rd_chk("data off mode", `USS_OFS_DATA, 8'h96, 8'hFF);
        rd_chk("status off mode", `USS_OFS_STATUS, 8'hC0, 8'hFF);
        $display("test three wire done");
    endtask

    // Start, stop, clock holds and open-drain data
    task automatic t_two();
        wr(`USS_OFS_PORT, 8'h67);
        wr(`USS_OFS_DATA, 8'hFF);
        wr(`USS_OFS_CONTROL, 8'h20);
        wr(`USS_OFS_STATUS, 8'hE0);
        tick(2);
        cmp("pullups", 8'h04, {5'h00, DATA_OUT_PULLUP, SDA_PULLUP, SCL_PULLUP});
        i_uss_peer.start_cond();
        tick(4);
        cmp("scl hold", 8'h01, {7'h00, SCL_OE});
        cmp("scl wire", 8'h00, {7'h00, SERIAL_CLOCK_PIN});
        rd_chk("start flag", `USS_OFS_STATUS, 8'h80, 8'h80);
        wr(`USS_OFS_STATUS, 8'h80);
        tick(3);
        cmp("scl freed", 8'h00, {7'h00, SCL_OE});
        i_uss_peer.stop_cond();
        tick(4);
        rd_chk("stop flag", `USS_OFS_STATUS, 8'h20, 8'hA0);
        wr(`USS_OFS_STATUS, 8'h20);
        rd_chk("stop clear", `USS_OFS_STATUS, 8'h00, 8'h20);
        wr(`USS_OFS_DATA, 8'h7F);
        tick(3);
        cmp("sda low", 8'h01, {7'h00, SDA_OE});
        rd_chk("no collision", `USS_OFS_STATUS, 8'h00, 8'h10);
        wr(`USS_OFS_STATUS, 8'h8F);
        wr(`USS_OFS_CONTROL, 8'h32);
        tick(1);
        cmp("ovf hold", 8'h01, {7'h00, SCL_OE});
        rd_chk("ovf flag", `USS_OFS_STATUS, 8'h40, 8'h4F);
        wr(`USS_OFS_STATUS, 8'h40);
        tick(3);
        cmp("ovf freed", 8'h00, {7'h00, SCL_OE});
        $display("test two wire done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset two cycles, let the pin synchronisers settle, then run
    initial
    begin
        repeat (2) @(posedge CLK_SYS);
        RST <= 1'h0;
        tick(4);
        t_reset();
        t_soft();
        t_ovf();
        t_three();
        t_two();
        results();
    end
endmodule
